// ===== design/ccw_defines.svh
// Offsets, field positions, reset values, opcodes and timing counts of the compare/complement block
`ifndef CCW_DEFINES_SVH
`define CCW_DEFINES_SVH
`define CCW_OFS_INSTR 8'h00
`define CCW_OFS_ACC 8'h04
`define CCW_OFS_BANKSEL 8'h08
`define CCW_OFS_STATUS 8'h0c
`define CCW_OFS_EXEC 8'h10
`define CCW_OFS_MADDR 8'h14
`define CCW_OFS_MDATA 8'h18
`define CCW_OFS_WDT 8'h1c
`define CCW_OFS_EA 8'h20
`define CCW_BIT_TWO_WORD 16
`define CCW_ST_C 0
`define CCW_ST_DC 1
`define CCW_ST_Z 2
`define CCW_ST_OV 3
`define CCW_ST_N 4
`define CCW_ST_TMO 5
`define CCW_ST_PWD 6
`define CCW_STATUS_RST 7'h60
`define CCW_ACC_RST 8'h00
`define CCW_BANKSEL_RST 4'h0
`define CCW_OPC_WDCLR 16'h0004
`define CCW_OPC_CMPL 6'h07
`define CCW_OPC_CPEQ 7'h31
`define CCW_OPC_CPGT 7'h32
`define CCW_OPC_CPLT 7'h30
`define CCW_ACC_SPLIT 8'h80
`define CCW_ACC_LOW_BANK 4'h0
`define CCW_ACC_HIGH_BANK 4'hf
`define CCW_Q_LAST 2'h3
`define CCW_MEM_DEPTH 16
`define CCW_MEM_IW 4
`endif

// ===== design/ccw_exec.sv
// Execute unit: decode, operand address, complement and unsigned compare
`timescale 1ns/1ps
`include "ccw_defines.svh"
module ccw_exec (
   ccw_exec_if.unit x
);
   wire [7:0] f_addr = x.instr[7:0];
   wire bank_bit = x.instr[8];
   wire is_wdclr = (x.instr == `CCW_OPC_WDCLR);
   wire is_cmpl = (x.instr[15:10] == `CCW_OPC_CMPL);
   wire is_cpeq = (x.instr[15:9] == `CCW_OPC_CPEQ);
   wire is_cpgt = (x.instr[15:9] == `CCW_OPC_CPGT);
   wire is_cplt = (x.instr[15:9] == `CCW_OPC_CPLT);
   wire [3:0] acc_bank = (f_addr < `CCW_ACC_SPLIT) ? `CCW_ACC_LOW_BANK : `CCW_ACC_HIGH_BANK;

   // Operand bank from the select register or the fixed access bank
   assign x.ea = bank_bit ? {x.banksel, f_addr} : {acc_bank, f_addr}; // see [RQ6] see [RQ7]
   // Complement of the operand byte
   assign x.result = ~x.rd_data; // see [RQ2]
   assign x.dest_f = x.instr[9];
   // Opcode class
   assign x.op = is_wdclr ? ccw_pkg::CCW_OP_WDCLR :
                 is_cmpl ? ccw_pkg::CCW_OP_CMPL :
                 is_cpeq ? ccw_pkg::CCW_OP_CPEQ : // see [RQ9]
                 is_cpgt ? ccw_pkg::CCW_OP_CPGT : // see [RQ10]
                 is_cplt ? ccw_pkg::CCW_OP_CPLT : ccw_pkg::CCW_OP_NONE; // see [RQ11]
   // Unsigned compare of operand byte against the accumulator
   assign x.skip = (is_cpeq && (x.rd_data == x.acc)) || // see [RQ8]
                   (is_cpgt && (x.rd_data > x.acc)) ||
                   (is_cplt && (x.rd_data < x.acc));
endmodule // ccw_exec

// ===== design/ccw_exec_if.sv
// Signals between the core sequencer and the execute unit
`timescale 1ns/1ps
interface ccw_exec_if;
   logic [15:0] instr;
   logic [7:0] rd_data;
   logic [7:0] acc;
   logic [3:0] banksel;
   logic [11:0] ea;
   logic [7:0] result;
   ccw_pkg::ccw_op_t op;
   logic dest_f;
   logic skip;
   modport core (output instr, rd_data, acc, banksel, input ea, result, op, dest_f, skip);
   modport unit (input instr, rd_data, acc, banksel, output ea, result, op, dest_f, skip);
endinterface

// ===== design/ccw_pkg.sv
// Types shared by the compare/complement block
package ccw_pkg;
   typedef enum logic [1:0] {CCW_S_IDLE, CCW_S_EXEC, CCW_S_SKIP} ccw_state_t;
   typedef enum logic [2:0] {CCW_OP_NONE, CCW_OP_WDCLR, CCW_OP_CMPL, CCW_OP_CPEQ,
                             CCW_OP_CPGT, CCW_OP_CPLT} ccw_op_t;
endpackage

// ===== design/ccw_top.sv
// Compare, complement and watchdog-clear execution block with AHB-Lite registers
// Function
// [RQ1] Watchdog clear zeroes the watchdog counter and postscaler and sets timeout and powerdown.
// [RQ2] Complement inverts every bit of the addressed byte and delivers it to the destination.
// [RQ3] Complement updates only the negative and zero flags from its result.
// [RQ4] With destination bit zero the complement result goes to the accumulator.
// [RQ5] With destination bit one the complement result goes back to the addressed byte.
// [RQ6] With bank bit zero the operand lies in the fixed access bank.
// [RQ7] With bank bit one the operand bank comes from the bank select register.
// [RQ8] Compares subtract unsigned, store nothing and change no status flag.
// [RQ9] Opcode 0110 001a skips when the byte equals the accumulator.
// [RQ10] Opcode 0110 010a skips when the byte is above the accumulator.
// [RQ11] Opcode 0110 000a skips when the byte is below the accumulator.
// [RQ12] A true compare discards the next instruction for one no-operation cycle.
// [RQ13] Skipping a two-word instruction costs two no-operation cycles, three in all.
// [RQ14] A false compare takes one cycle and the next instruction runs normally.
`timescale 1ns/1ps
`include "ccw_defines.svh"
module ccw_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   ccw_exec_if x ();
   ccw_exec u_exec (.x(x));

   ccw_pkg::ccw_state_t state_r, state_nxt;
   logic [1:0] q_r;
   logic [1:0] skip_left_r;
   logic [16:0] instr_r;
   logic [7:0] acc_r;
   logic [3:0] banksel_r;
   logic [6:0] status_r;
   logic [11:0] maddr_r;
   logic [11:0] ea_r;
   logic [7:0] wdt_cnt_r;
   logic [7:0] wdt_post_r;
   logic [7:0] mem_r [`CCW_MEM_DEPTH];
   logic skip_taken_r;
   logic [1:0] cycles_r;
   logic unknown_r;
   logic dp_valid_r;
   logic dp_write_r;
   logic [7:0] dp_addr_r;
   logic [31:0] hrdata_r;

   // Bus decode
   wire addr_phase = hsel && htrans[1] && hready;
   wire busy = (state_r != ccw_pkg::CCW_S_IDLE);
   wire bus_wr = dp_valid_r && dp_write_r && !busy;
   wire wr_instr = bus_wr && (dp_addr_r == `CCW_OFS_INSTR);
   wire wr_acc = bus_wr && (dp_addr_r == `CCW_OFS_ACC);
   wire wr_banksel = bus_wr && (dp_addr_r == `CCW_OFS_BANKSEL);
   wire wr_status = bus_wr && (dp_addr_r == `CCW_OFS_STATUS);
   wire wr_maddr = bus_wr && (dp_addr_r == `CCW_OFS_MADDR);
   wire wr_mdata = bus_wr && (dp_addr_r == `CCW_OFS_MDATA);
   wire [`CCW_MEM_IW-1:0] midx = maddr_r[`CCW_MEM_IW-1:0];

   // Execute-unit hookup
   wire [`CCW_MEM_IW-1:0] eidx = x.ea[`CCW_MEM_IW-1:0];
   assign x.instr = instr_r[15:0];
   assign x.rd_data = mem_r[eidx];
   assign x.acc = acc_r;
   assign x.banksel = banksel_r;
   wire commit = (state_r == ccw_pkg::CCW_S_EXEC) && (q_r == `CCW_Q_LAST);
   wire do_wdclr = commit && (x.op == ccw_pkg::CCW_OP_WDCLR);
   wire do_cmpl = commit && (x.op == ccw_pkg::CCW_OP_CMPL);
   wire cmpl_to_acc = do_cmpl && !x.dest_f;
   wire cmpl_to_mem = do_cmpl && x.dest_f;
   wire is_cmp = (x.op == ccw_pkg::CCW_OP_CPEQ) || (x.op == ccw_pkg::CCW_OP_CPGT) ||
                 (x.op == ccw_pkg::CCW_OP_CPLT);
   wire skip_go = commit && x.skip;
   wire [1:0] skip_len = instr_r[`CCW_BIT_TWO_WORD] ? 2'h2 : 2'h1;
   wire skip_end = (state_r == ccw_pkg::CCW_S_SKIP) && (q_r == `CCW_Q_LAST) &&
                   (skip_left_r == 2'h1);

   // Register read mux
   logic [31:0] rd_mux;
   assign rd_mux = (haddr[7:0] == `CCW_OFS_INSTR) ? {15'h0000, instr_r} :
                   (haddr[7:0] == `CCW_OFS_ACC) ? {24'h000000, acc_r} :
                   (haddr[7:0] == `CCW_OFS_BANKSEL) ? {28'h0000000, banksel_r} :
                   (haddr[7:0] == `CCW_OFS_STATUS) ? {25'h0000000, status_r} :
                   (haddr[7:0] == `CCW_OFS_EXEC) ?
                      {27'h0000000, unknown_r, cycles_r, skip_taken_r, busy} :
                   (haddr[7:0] == `CCW_OFS_MADDR) ? {20'h00000, maddr_r} :
                   (haddr[7:0] == `CCW_OFS_MDATA) ? {24'h000000, mem_r[midx]} :
                   (haddr[7:0] == `CCW_OFS_WDT) ? {16'h0000, wdt_post_r, wdt_cnt_r} :
                   (haddr[7:0] == `CCW_OFS_EA) ? {20'h00000, ea_r} : 32'h00000000;
   wire rd_hit = (haddr[31:8] == 24'h000000) && !hwrite;

   // Next sequencer state
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ccw_pkg::CCW_S_IDLE:
            if (wr_instr)
               state_nxt = ccw_pkg::CCW_S_EXEC;
         ccw_pkg::CCW_S_EXEC:
            if (commit)
               state_nxt = x.skip ? ccw_pkg::CCW_S_SKIP : ccw_pkg::CCW_S_IDLE; // see [RQ14]
         ccw_pkg::CCW_S_SKIP:
            if (skip_end)
               state_nxt = ccw_pkg::CCW_S_IDLE;
         default:
            state_nxt = ccw_pkg::CCW_S_IDLE;
      endcase
   end

   // AHB data phase tracking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
      end
      else
      begin
         dp_valid_r <= addr_phase && (haddr[31:8] == 24'h000000);
         dp_write_r <= hwrite;
         dp_addr_r <= haddr[7:0];
         if (addr_phase)
            hrdata_r <= rd_hit ? rd_mux : 32'h00000000;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Sequencer: four clocks per instruction cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= ccw_pkg::CCW_S_IDLE;
         q_r <= 2'h0;
         skip_left_r <= 2'h0;
         skip_taken_r <= 1'b0;
         cycles_r <= 2'h0;
         unknown_r <= 1'b0;
         ea_r <= 12'h000;
      end
      else
      begin
         state_r <= state_nxt;
         q_r <= (state_r == ccw_pkg::CCW_S_IDLE) ? 2'h0 : q_r + 2'h1;
         if (wr_instr)
         begin
            skip_taken_r <= 1'b0;
            cycles_r <= 2'h0;
         end
         if (commit)
         begin
            ea_r <= x.ea;
            unknown_r <= (x.op == ccw_pkg::CCW_OP_NONE);
            skip_taken_r <= x.skip;
            skip_left_r <= x.skip ? skip_len : 2'h0; // see [RQ12] see [RQ13]
            cycles_r <= x.skip ? skip_len + 2'h1 : 2'h1;
         end
         else if ((state_r == ccw_pkg::CCW_S_SKIP) && (q_r == `CCW_Q_LAST))
            skip_left_r <= skip_left_r - 2'h1;
      end
   end

   // Instruction, accumulator, bank select and memory pointer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         instr_r <= 17'h00000;
         acc_r <= `CCW_ACC_RST;
         banksel_r <= `CCW_BANKSEL_RST;
         maddr_r <= 12'h000;
      end
      else
      begin
         if (wr_instr)
            instr_r <= hwdata[16:0];
         if (wr_acc)
            acc_r <= hwdata[7:0];
         else if (cmpl_to_acc)
            acc_r <= x.result; // see [RQ4]
         if (wr_banksel)
            banksel_r <= hwdata[3:0];
         if (wr_maddr)
            maddr_r <= hwdata[11:0];
      end
   end

   // Status flags: complement touches only N and Z
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         status_r <= `CCW_STATUS_RST;
      else
      begin
         if (wr_status)
            status_r <= hwdata[6:0];
         if (do_cmpl)
         begin
            status_r[`CCW_ST_N] <= x.result[7]; // see [RQ3]
            status_r[`CCW_ST_Z] <= (x.result == 8'h00);
         end
         if (do_wdclr)
         begin
            status_r[`CCW_ST_TMO] <= 1'b1; // see [RQ1]
            status_r[`CCW_ST_PWD] <= 1'b1;
         end
      end
   end

   // Watchdog counter and postscaler
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wdt_cnt_r <= 8'h00;
         wdt_post_r <= 8'h00;
      end
      else if (do_wdclr)
      begin
         wdt_cnt_r <= 8'h00; // see [RQ1]
         wdt_post_r <= 8'h00;
      end
      else
      begin
         wdt_cnt_r <= wdt_cnt_r + 8'h01;
         if (wdt_cnt_r == 8'hff)
            wdt_post_r <= wdt_post_r + 8'h01;
      end
   end

   // Data memory
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < `CCW_MEM_DEPTH; i++)
            mem_r[i] <= 8'h00;
      end
      else if (wr_mdata)
         mem_r[midx] <= hwdata[7:0];
      else if (cmpl_to_mem)
         mem_r[eidx] <= x.result; // see [RQ5]
   end

   // Checks
   AST_WDT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ1]
      do_wdclr |=> (wdt_cnt_r == 8'h00) && (wdt_post_r == 8'h00) &&
                   status_r[`CCW_ST_TMO] && status_r[`CCW_ST_PWD])
      else $error("watchdog clear did not take effect");
   AST_CMPL_INVERT: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ2]
      do_cmpl |=> (($past(x.dest_f) ? mem_r[$past(eidx)] : acc_r) == ~$past(x.rd_data)))
      else $error("complement result not inverted");
   AST_CMPL_FLAGS: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ3]
      do_cmpl |=> (status_r[`CCW_ST_Z] == ($past(x.result) == 8'h00)) &&
                  (status_r[`CCW_ST_N] == $past(x.result[7])) &&
                  (status_r[3:0] & 4'hb) == ($past(status_r[3:0]) & 4'hb) &&
                  $stable(status_r[6:5]))
      else $error("complement flags wrong");
   AST_DEST_W: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ4]
      cmpl_to_acc |=> (acc_r == $past(x.result)) && (mem_r[$past(eidx)] == $past(x.rd_data)))
      else $error("complement to accumulator wrong");
   AST_DEST_F: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ5]
      cmpl_to_mem |=> (mem_r[$past(eidx)] == $past(x.result)) && $stable(acc_r))
      else $error("complement to memory wrong");
   AST_ACCESS_BANK: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ6]
      (busy && !instr_r[8] && (x.op != ccw_pkg::CCW_OP_NONE)) |->
         (x.ea[11:8] == (instr_r[7] ? `CCW_ACC_HIGH_BANK : `CCW_ACC_LOW_BANK)))
      else $error("access bank address wrong");
   AST_SEL_BANK: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ7]
      (busy && instr_r[8]) |-> (x.ea == {banksel_r, instr_r[7:0]}))
      else $error("bank select address wrong");
   AST_CMP_NO_STORE: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ8]
      (commit && is_cmp) |=> $stable(status_r) && $stable(acc_r) &&
                             (mem_r[$past(eidx)] == $past(x.rd_data)))
      else $error("compare altered state");
   AST_EQ_SKIP: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ9]
      (commit && (instr_r[15:9] == `CCW_OPC_CPEQ)) |->
         (x.skip == (mem_r[instr_r[3:0]] == acc_r)))
      else $error("equal compare wrong");
   AST_GT_SKIP: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ10]
      (commit && (instr_r[15:9] == `CCW_OPC_CPGT)) |->
         (x.skip == (mem_r[instr_r[3:0]] > acc_r)))
      else $error("greater compare wrong");
   AST_LT_SKIP: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ11]
      (commit && (instr_r[15:9] == `CCW_OPC_CPLT)) |->
         (x.skip == (mem_r[instr_r[3:0]] < acc_r)))
      else $error("less compare wrong");
   AST_SKIP_ONE: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ12]
      (skip_go && !instr_r[`CCW_BIT_TWO_WORD]) |=>
         (state_r == ccw_pkg::CCW_S_SKIP) [*4] ##1 (state_r == ccw_pkg::CCW_S_IDLE))
      else $error("single skip length wrong");
   AST_SKIP_TWO: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ13]
      (skip_go && instr_r[`CCW_BIT_TWO_WORD]) |=>
         (state_r == ccw_pkg::CCW_S_SKIP) [*8] ##1 (state_r == ccw_pkg::CCW_S_IDLE))
      else $error("double skip length wrong");
   AST_NO_SKIP: assert property (@(posedge hclk) disable iff (!hresetn) // see [RQ14]
      (commit && !x.skip) |=> (state_r == ccw_pkg::CCW_S_IDLE) && (cycles_r == 2'h1))
      else $error("non-skip compare too long");
endmodule // ccw_top

// ===== verif/compare_complement_wdt_ops_tb.sv
// Self-checking bench for the compare, complement and watchdog-clear block
`timescale 1ns/1ps
`include "ccw_defines.svh"
module compare_complement_wdt_ops_tb;
   logic hclk;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   int n_errors = 0;
   int num_checks = 0;
   logic [15:0] cmp_opc [3] = '{16'h6200, 16'h6400, 16'h6000};
   int skip_at [3] = '{1, 0, 2};
   logic [8:0] bank_af [3] = '{9'h012, 9'h085, 9'h185};
   logic [11:0] bank_ea [3] = '{12'h012, 12'hf85, 12'h385};

   // Device under test, the bus ready loops back from the slave
   ccw_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));

   // Clock of 100 ns period
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // Compare one value and count it
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h got %h", what, exp, got);
      end
   endtask

   // Counts, verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Waits for the next edge with hready high
   task automatic wait_rdy();
      int n;
      @(posedge hclk);
      for (n = 0; n < 50 && hreadyout !== 1'b1; n++) @(posedge hclk);
      if (hreadyout !== 1'b1)
      begin
         n_errors++;
         $display("Error hready expected 1 got %b", hreadyout);
      end
   endtask

   // Single word write, address phase then data phase
   task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= 1'b1;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   // Single word read, data taken at the data phase edge
   task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= 1'b0;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      wait_rdy();
      d = hrdata;
   endtask

   // Loads an instruction and polls until it has retired
   task automatic run_op(input logic [16:0] w, output logic [31:0] ex);
      int n;
      ahb_write(`CCW_OFS_INSTR, {15'h0, w});
      ex = 32'h1;
      for (n = 0; n < 40 && ex[0] !== 1'b0; n++) ahb_read(`CCW_OFS_EXEC, ex);
      chk("retired", 32'h0, {31'h0, ex[0]});
   endtask

   // Memory byte access through pointer and data registers
   task automatic mem_io(input logic wr, input logic [3:0] idx, inout logic [31:0] d);
      ahb_write(`CCW_OFS_MADDR, {28'h0, idx});
      if (wr)
         ahb_write(`CCW_OFS_MDATA, d);
      else
         ahb_read(`CCW_OFS_MDATA, d);
   endtask

   // Reset values and an unmapped address
   task automatic t_reset();
      logic [31:0] d;
      ahb_read(`CCW_OFS_STATUS, d);
      chk("status", 32'h60, d);
      ahb_read(`CCW_OFS_ACC, d);
      chk("acc", 32'h0, d);
      ahb_read(`CCW_OFS_EXEC, d);
      chk("exec", 32'h0, d);
      ahb_write(8'h40, 32'hffffffff);
      ahb_read(8'h40, d);
      chk("unmapped", 32'h0, d);
      chk("hresp", 32'h0, {31'h0, hresp});
      $display("test reset done");
   endtask

   // Complement into accumulator, then back into memory
   task automatic t_comp();
      logic [31:0] d;
      d = 32'h13;
      mem_io(1'b1, 4'h5, d);
      d = 32'hff;
      mem_io(1'b1, 4'h6, d);
      ahb_write(`CCW_OFS_ACC, 32'h11);
      ahb_write(`CCW_OFS_STATUS, 32'h6f);
      run_op(17'h1c05, d);
      ahb_read(`CCW_OFS_ACC, d);
      chk("comp acc", 32'hec, d);
      mem_io(1'b0, 4'h5, d);
      chk("comp mem kept", 32'h13, d);
      ahb_read(`CCW_OFS_STATUS, d);
      chk("comp status n", 32'h7b, d);
      run_op(17'h1e06, d);
      mem_io(1'b0, 4'h6, d);
      chk("comp mem", 32'h00, d);
      ahb_read(`CCW_OFS_ACC, d);
      chk("comp acc kept", 32'hec, d);
      ahb_read(`CCW_OFS_STATUS, d);
      chk("comp status z", 32'h6f, d);
      $display("test complement done");
   endtask

   // Operand bank from access bank or bank select
   task automatic t_bank();
      logic [31:0] d;
      ahb_write(`CCW_OFS_BANKSEL, 32'h3);
      for (int i = 0; i < 3; i++)
      begin
         run_op({8'h31, bank_af[i]}, d);
         ahb_read(`CCW_OFS_EA, d);
         chk("ea", {20'h0, bank_ea[i]}, d);
      end
      run_op(17'h0ffff, d);
      chk("unknown exec", 32'h14, {27'h0, d[4:0]});
      $display("test bank done");
   endtask

   // Every compare against below, equal and above, with two-word skip for one
   task automatic t_cmp();
      logic [31:0] d;
      logic sk;
      logic tw;
      d = 32'h50;
      mem_io(1'b1, 4'h2, d);
      for (int k = 0; k < 3; k++)
         for (int j = 0; j < 3; j++)
         begin
            sk = (j == skip_at[k]);
            tw = (k == 1);
            ahb_write(`CCW_OFS_ACC, 32'h4f + j);
            ahb_write(`CCW_OFS_STATUS, 32'h15);
            run_op({tw, cmp_opc[k] | 16'h0002}, d);
            chk("cmp exec", {27'h0, 1'b0, sk ? (tw ? 2'h3 : 2'h2) : 2'h1, sk, 1'b0},
               {27'h0, d[4:0]});
            ahb_read(`CCW_OFS_STATUS, d);
            chk("cmp status", 32'h15, d);
            ahb_read(`CCW_OFS_ACC, d);
            chk("cmp acc", 32'h4f + j, d);
            mem_io(1'b0, 4'h2, d);
            chk("cmp mem", 32'h50, d);
         end
      $display("test compare done");
   endtask

   // Watchdog clear, with a write refused while busy
   task automatic t_wdt();
      logic [31:0] d;
      repeat (600) @(posedge hclk);
      ahb_write(`CCW_OFS_STATUS, 32'h00);
      ahb_write(`CCW_OFS_ACC, 32'h33);
      ahb_write(`CCW_OFS_INSTR, {16'h0, `CCW_OPC_WDCLR});
      ahb_write(`CCW_OFS_ACC, 32'haa);
      ahb_read(`CCW_OFS_EXEC, d);
      chk("busy", 32'h1, {31'h0, d[0]});
      run_op(17'h00000, d);
      ahb_read(`CCW_OFS_WDT, d);
      chk("postscaler", 32'h0, {24'h0, d[15:8]});
      chk("counter low", 32'h1, {31'h0, d[7:0] < 8'h30});
      ahb_read(`CCW_OFS_STATUS, d);
      chk("wdt status", 32'h60, d);
      ahb_read(`CCW_OFS_ACC, d);
      chk("acc refused", 32'h33, d);
      $display("test watchdog done");
   endtask

   // Hang guard
   initial
   begin
      #(40000 * 100);
      n_errors++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_comp();
      t_bank();
      t_cmp();
      t_wdt();
      end_sim();
   end
endmodule // compare_complement_wdt_ops_tb
